// >>> evt_timer.sv
/*
 * event timer with selectable clock and reset sources, capture inputs,
 * a compare store that fires actions on free-running or event timer counts,
 * and an APB register slave with sticky status, mask and interrupts.
 * assumes all pins are synchronous-ish levels sampled on ref_clk_i and a
 * single 100 MHz clock with synchronous active-high reset.
 */
// Notes on behaviour
// - with the reset pin selected, each rising edge on it clears the event timer.
// - capture input zero may be chosen as the reset source, and its edge then also interrupts and records a time.
// - capture input zero has its own interrupt output, raised on its edge when its mask bit is set, apart from the shared interrupt line.
// - capture input one may clock the event timer in place of the clock pin, and its edges are timestamped too.
// - a compare command can reset the event timer when its count equals a programmed value.
// - every pending compare command, software events included, holds one entry of the compare store.
// - the event timer counts up by one on each active edge of its selected clock input, except when a reset acts in the same cycle.
// - compare commands may match on the event timer count as well as on the free-running timer.
`timescale 1ns/100ps
`include "evt_timer_map.svh"

module evt_timer (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // sensor pins
    input wire logic ext_timer_clock_pin_i,
    input wire logic ext_timer_reset_pin_i,
    input wire logic capture0_pin_i,
    input wire logic capture1_pin_i,
    // compare outputs and interrupts
    output logic [`LINE_CNT-1:0] compare_line_o,
    output logic cap0_irq_o,
    output logic irq_o
);

    // pin order: 0 clock pin, 1 reset pin, 2 capture0, 3 capture1
    logic [3:0] pin_raw;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] prev_r;
    logic [3:0] rise;

    // named edges, so the source selection below reads by function
    logic clk_pin_rise;
    logic rst_pin_rise;
    logic cap0_rise;
    logic cap1_rise;

    assign pin_raw = {capture1_pin_i, capture0_pin_i, ext_timer_reset_pin_i, ext_timer_clock_pin_i};

    // sync flops carry no reset: a pin already high at reset gives no false edge
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge ref_clk_i) begin
                sync1_r[g] <= pin_raw[g];
                sync2_r[g] <= sync1_r[g];
                prev_r[g] <= sync2_r[g];
            end
            assign rise[g] = sync2_r[g] & ~prev_r[g] & ~sys_rst_i;
        end
    endgenerate

    assign clk_pin_rise = rise[0];
    assign rst_pin_rise = rise[1];
    assign cap0_rise = rise[2];
    assign cap1_rise = rise[3];

    function automatic evt_timer_pkg::rst_src_t rst_decode(input logic [1:0] f);
        unique case (f)
            2'h1: rst_decode = evt_timer_pkg::RST_SRC_CAP0;
            2'h2: rst_decode = evt_timer_pkg::RST_SRC_COMPARE;
            default: rst_decode = evt_timer_pkg::RST_SRC_PIN;
        endcase
    endfunction

    function automatic logic addr_mapped(input logic [`ADDR_W-1:0] a);
        addr_mapped = (a == `OFS_CTRL) || (a == `OFS_EVT_COUNT) || (a == `OFS_FREE_TIME) ||
                      (a == `OFS_CAP0_TIME) || (a == `OFS_CAP1_TIME) || (a == `OFS_STATUS) ||
                      (a == `OFS_MASK) || (a == `OFS_CMD) || (a == `OFS_STORE);
    endfunction

    // state
    evt_timer_pkg::clk_src_t clk_src_r, clk_src_nxt;
    evt_timer_pkg::rst_src_t rst_src_r, rst_src_nxt;
    logic [`TMR_W-1:0] evt_cnt_r, evt_cnt_nxt;
    logic [`TMR_W-1:0] free_r, free_nxt;
    logic [`TMR_W-1:0] cap0_time_r, cap0_time_nxt;
    logic [`TMR_W-1:0] cap1_time_r, cap1_time_nxt;
    logic [`ST_W-1:0] status_r, status_nxt;
    logic [`ST_W-1:0] mask_r, mask_nxt;
    logic [`LINE_CNT-1:0] line_r, line_nxt;
    logic [`STORE_DEPTH-1:0] ent_valid_r, ent_valid_nxt;
    logic [`TMR_W-1:0] ent_value_r [`STORE_DEPTH];
    logic [`TMR_W-1:0] ent_value_nxt [`STORE_DEPTH];
    logic [`STORE_DEPTH-1:0] ent_base_r, ent_base_nxt;
    evt_timer_pkg::action_t ent_act_r [`STORE_DEPTH];
    evt_timer_pkg::action_t ent_act_nxt [`STORE_DEPTH];
    logic [1:0] ent_line_r [`STORE_DEPTH];
    logic [1:0] ent_line_nxt [`STORE_DEPTH];
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;

    // combinational helpers
    logic setup;
    logic wr;
    logic clk_edge;
    logic cmp_rst;
    logic cmp_sw;
    logic evt_reset;
    logic alloc_done;
    logic [`ST_W-1:0] st_set;
    logic [`ST_W-1:0] st_clr;
    logic [`STORE_DEPTH-1:0] fire;
    logic [3:0] used_cnt;

    assign setup = psel_i & ~penable_i;
    assign wr = psel_i & penable_i & pwrite_i & addr_mapped(paddr_i);

    always_comb begin
        clk_src_nxt = clk_src_r;
        rst_src_nxt = rst_src_r;
        free_nxt = free_r + `TMR_W'(1);
        cap0_time_nxt = cap0_time_r;
        cap1_time_nxt = cap1_time_r;
        mask_nxt = mask_r;
        line_nxt = line_r;
        ent_valid_nxt = ent_valid_r;
        ent_base_nxt = ent_base_r;
        ent_value_nxt = ent_value_r;
        ent_act_nxt = ent_act_r;
        ent_line_nxt = ent_line_r;
        cmp_rst = 1'b0;
        cmp_sw = 1'b0;
        alloc_done = 1'b0;
        st_set = '0;
        st_clr = '0;
        used_cnt = 4'h0;

        // compare store: each valid entry watches its own timebase
        // a value already passed waits for its timer to wrap round
        for (int i = 0; i < `STORE_DEPTH; i++) begin
            fire[i] = ent_valid_r[i] &&
                      (ent_value_r[i] == (ent_base_r[i] ? evt_cnt_r : free_r));
            if (fire[i]) begin
                ent_valid_nxt[i] = 1'b0;
                unique case (ent_act_r[i])
                    evt_timer_pkg::ACT_SW_EVENT: cmp_sw = 1'b1;
                    evt_timer_pkg::ACT_RESET_EVT: cmp_rst = 1'b1;
                    evt_timer_pkg::ACT_SET_LINE: line_nxt[ent_line_r[i]] = 1'b1;
                    evt_timer_pkg::ACT_CLR_LINE: line_nxt[ent_line_r[i]] = 1'b0;
                endcase
            end
            if (ent_valid_r[i]) begin
                used_cnt = used_cnt + 4'h1;
            end
        end

        // clock source choice
        clk_edge = (clk_src_r == evt_timer_pkg::CLK_SRC_CAP1) ? cap1_rise : clk_pin_rise;

        // exactly one reset source acts
        unique case (rst_src_r)
            evt_timer_pkg::RST_SRC_PIN: evt_reset = rst_pin_rise;
            evt_timer_pkg::RST_SRC_CAP0: evt_reset = cap0_rise;
            evt_timer_pkg::RST_SRC_COMPARE: evt_reset = cmp_rst;
            default: evt_reset = 1'b0;
        endcase

        // reset wins over a clock edge in the same cycle
        if (evt_reset) begin
            evt_cnt_nxt = '0;
        end else if (clk_edge) begin
            evt_cnt_nxt = evt_cnt_r + `TMR_W'(1);
        end else begin
            evt_cnt_nxt = evt_cnt_r;
        end

        // capture0 always stamps and flags, whether or not it is the reset source
        if (cap0_rise) begin
            cap0_time_nxt = free_r;
            st_set[`ST_CAP0] = 1'b1;
        end
        if (cap1_rise) begin
            cap1_time_nxt = free_r;
            st_set[`ST_CAP1] = 1'b1;
        end
        st_set[`ST_SWEVT] = cmp_sw;
        st_set[`ST_EVT_RST] = evt_reset;

        // register writes
        if (wr) begin
            unique case (paddr_i)
                `OFS_CTRL: begin
                    clk_src_nxt = evt_timer_pkg::clk_src_t'(pwdata_i[`CTRL_CLK_BIT]);
                    rst_src_nxt = rst_decode(pwdata_i[`CTRL_RST_MSB:`CTRL_RST_LSB]);
                end
                `OFS_STATUS: st_clr = pwdata_i[`ST_W-1:0];
                `OFS_MASK: mask_nxt = pwdata_i[`ST_W-1:0];
                `OFS_CMD: begin
                    // first free slot takes the command; a full store drops it
                    for (int i = 0; i < `STORE_DEPTH; i++) begin
                        if (!ent_valid_r[i] && !alloc_done) begin
                            alloc_done = 1'b1;
                            ent_valid_nxt[i] = 1'b1;
                            ent_value_nxt[i] = pwdata_i[`TMR_W-1:0];
                            ent_base_nxt[i] = pwdata_i[`CMD_BASE_BIT];
                            ent_act_nxt[i] = evt_timer_pkg::action_t'(
                                pwdata_i[`CMD_ACT_MSB:`CMD_ACT_LSB]);
                            ent_line_nxt[i] = pwdata_i[`CMD_LINE_MSB:`CMD_LINE_LSB];
                        end
                    end
                    st_set[`ST_OVFL] = ~alloc_done;
                end
                default: ;
            endcase
        end

        // set beats a simultaneous write-one clear
        status_nxt = (status_r & ~st_clr) | st_set;

        // read data is captured in the setup cycle, so the access phase needs no wait
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup) begin
            pslverr_nxt = ~addr_mapped(paddr_i);
            unique case (paddr_i)
                `OFS_CTRL: prdata_nxt = {29'h0, rst_src_r, clk_src_r};
                `OFS_EVT_COUNT: prdata_nxt = {16'h0, evt_cnt_r};
                `OFS_FREE_TIME: prdata_nxt = {16'h0, free_r};
                `OFS_CAP0_TIME: prdata_nxt = {16'h0, cap0_time_r};
                `OFS_CAP1_TIME: prdata_nxt = {16'h0, cap1_time_r};
                `OFS_STATUS: prdata_nxt = {27'h0, status_r};
                `OFS_MASK: prdata_nxt = {27'h0, mask_r};
                `OFS_STORE: prdata_nxt = {20'h0, line_r, 4'h0, used_cnt};
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            clk_src_r <= evt_timer_pkg::CLK_SRC_PIN;
            rst_src_r <= evt_timer_pkg::RST_SRC_PIN;
            evt_cnt_r <= '0;
            free_r <= '0;
            cap0_time_r <= '0;
            cap1_time_r <= '0;
            status_r <= '0;
            mask_r <= `MASK_RST;
            line_r <= `LINE_RST;
            ent_valid_r <= '0;
            ent_base_r <= '0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            for (int i = 0; i < `STORE_DEPTH; i++) begin
                ent_value_r[i] <= '0;
                ent_act_r[i] <= evt_timer_pkg::ACT_SW_EVENT;
                ent_line_r[i] <= 2'h0;
            end
        end else begin
            clk_src_r <= clk_src_nxt;
            rst_src_r <= rst_src_nxt;
            evt_cnt_r <= evt_cnt_nxt;
            free_r <= free_nxt;
            cap0_time_r <= cap0_time_nxt;
            cap1_time_r <= cap1_time_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            line_r <= line_nxt;
            ent_valid_r <= ent_valid_nxt;
            ent_base_r <= ent_base_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            ent_value_r <= ent_value_nxt;
            ent_act_r <= ent_act_nxt;
            ent_line_r <= ent_line_nxt;
        end
    end

    // outputs
    assign prdata_o = prdata_r;
    // read data was loaded at setup, so every access ends in one cycle
    assign pready_o = 1'b1;
    assign pslverr_o = pslverr_r & psel_i & penable_i;
    assign compare_line_o = line_r;
    // capture0 keeps a vector of its own, apart from the shared line
    assign cap0_irq_o = status_r[`ST_CAP0] & mask_r[`ST_CAP0];
    // the shared line leaves capture0 out, so software is not called twice
    assign irq_o = |(status_r & mask_r & ~(`ST_W'(1) << `ST_CAP0));

endmodule

// >>> evt_timer_map.svh
/*
 * register offsets, field positions, reset values and sizes of the event timer block.
 * assumes an APB slave with 12-bit byte addresses and 32-bit data.
 */
`ifndef EVT_TIMER_MAP_SVH
`define EVT_TIMER_MAP_SVH

`define ADDR_W 12
`define TMR_W 16
`define STORE_DEPTH 8
`define LINE_CNT 4

`define OFS_CTRL 12'h000
`define OFS_EVT_COUNT 12'h004
`define OFS_FREE_TIME 12'h008
`define OFS_CAP0_TIME 12'h00c
`define OFS_CAP1_TIME 12'h010
`define OFS_STATUS 12'h014
`define OFS_MASK 12'h018
`define OFS_CMD 12'h01c
`define OFS_STORE 12'h020

`define CTRL_CLK_BIT 0
`define CTRL_RST_LSB 1
`define CTRL_RST_MSB 2

`define ST_CAP0 0
`define ST_CAP1 1
`define ST_SWEVT 2
`define ST_OVFL 3
`define ST_EVT_RST 4
`define ST_W 5

`define CMD_BASE_BIT 16
`define CMD_ACT_LSB 17
`define CMD_ACT_MSB 18
`define CMD_LINE_LSB 19
`define CMD_LINE_MSB 20

`define STORE_LINE_LSB 8

`define MASK_RST 5'h00
`define LINE_RST 4'h0

`endif

// >>> evt_timer_pkg.sv
/*
 * types of the event timer block: clock source, reset source and compare action.
 * assumes evt_timer_map.svh supplies all numeric constants.
 */
package evt_timer_pkg;

    typedef enum logic {CLK_SRC_PIN, CLK_SRC_CAP1} clk_src_t;

    typedef enum logic [1:0] {RST_SRC_PIN, RST_SRC_CAP0, RST_SRC_COMPARE} rst_src_t;

    typedef enum logic [1:0] {ACT_SW_EVENT, ACT_RESET_EVT, ACT_SET_LINE, ACT_CLR_LINE} action_t;

endpackage

// >>> evt_timer_properties.sv
/* port checker of the event timer: apb answer, error and interrupt timing.
   assumes it is bound to evt_timer and sees only its ports. */
`timescale 1ns/100ps
`include "evt_timer_map.svh"
module evt_timer_properties (
    // clock, reset and apb
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`ADDR_W-1:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // pins and interrupts
    input wire logic capture0_pin_i,
    input wire logic cap0_irq_o,
    input wire logic irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [5:0] c0_hist_r;
    logic [5:0] c0_hist_nxt;
    // six samples cover the two-stage sync plus edge detect, with margin
    always_comb begin
        c0_hist_nxt = {c0_hist_r[4:0], capture0_pin_i};
    end
    always_ff @(posedge ref_clk_i) begin
        c0_hist_r <= c0_hist_nxt;
    end
    pready_a: assert property (pready_o)
        else $error("ready low");
    err_phase_a: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("error outside access phase");
    unmapped_err_a: assert property (psel_i && penable_i && paddr_i > `OFS_STORE |-> pslverr_o)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel_i && penable_i && paddr_i <= `OFS_STORE
        && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
        else $error("mapped access refused");
    err_data_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("refused read returned data");
    rdata_hold_a: assert property ($changed(prdata_o) |-> $past(psel_i && !penable_i))
        else $error("read data moved outside setup");
    cap0_rise_a: assert property ($rose(cap0_irq_o) |->
        $past(psel_i && penable_i && pwrite_i) || (|c0_hist_r))
        else $error("capture zero interrupt without cause");
    cap0_fall_a: assert property ($fell(cap0_irq_o) |-> $past(psel_i && penable_i && pwrite_i))
        else $error("capture zero interrupt dropped by itself");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(psel_i && penable_i && pwrite_i))
        else $error("interrupt dropped by itself");
endmodule
bind evt_timer evt_timer_properties evt_timer_properties_inst (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .capture0_pin_i(capture0_pin_i), .cap0_irq_o(cap0_irq_o), .irq_o(irq_o));

// >>> sensor_model.sv
/* tooth and index sensor driving the four sensor pins of the event timer.
   assumes the bench calls pulse(); pins are push-pull and idle low. */
`timescale 1ns/100ps
module sensor_model (
    // clock
    input wire logic ref_clk_i,
    // sensor pins
    output logic clk_pin_o,
    output logic rst_pin_o,
    output logic cap0_o,
    output logic cap1_o
);
    logic [3:0] pins_r = 4'h0;
    assign {cap1_o, cap0_o, rst_pin_o, clk_pin_o} = pins_r;
    // hi sets the high phase and the low phase lasts hi+1 cycles; 1 is the fastest edge rate the timer resolves
    task automatic pulse(input int sel, input int n, input int hi);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk_i) pins_r[sel] <= 1'b1;
            repeat (hi) @(posedge ref_clk_i);
            pins_r[sel] <= 1'b0;
            repeat (hi) @(posedge ref_clk_i);
        end
    endtask
endmodule

// >>> tb_evt_timer.sv
/* self-checking bench of the event timer over apb, with a sensor model.
   assumes the map header, evt_timer and sensor_model are compiled first. */
`timescale 1ns/100ps
`include "evt_timer_map.svh"
module tb_evt_timer;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [`ADDR_W-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic clk_pin, rst_pin, cap0_pin, cap1_pin;
    logic [`LINE_CNT-1:0] compare_line_o;
    logic cap0_irq_o;
    logic irq_o;
    logic [31:0] q;
    logic err;
    logic [15:0] t0;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    evt_timer evt_timer_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ext_timer_clock_pin_i(clk_pin), .ext_timer_reset_pin_i(rst_pin),
        .capture0_pin_i(cap0_pin), .capture1_pin_i(cap1_pin),
        .compare_line_o(compare_line_o), .cap0_irq_o(cap0_irq_o), .irq_o(irq_o));
    sensor_model sensor_model_inst (.ref_clk_i(ref_clk_i), .clk_pin_o(clk_pin),
        .rst_pin_o(rst_pin), .cap0_o(cap0_pin), .cap1_o(cap1_pin));
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        @(posedge ref_clk_i);
        while (pready_o !== 1'b1) @(posedge ref_clk_i);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
        chk({31'h0, err}, {31'h0, a > `OFS_STORE});
    endtask
    // a hang is cut here; the run needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_sim;
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_MASK, {27'h0, `MASK_RST});
        rd(`OFS_STATUS, 32'h0);
        rd(`OFS_STORE, 32'h0);
        rd(12'h040, 32'h0);
        sensor_model_inst.pulse(0, 5, 2);
        sensor_model_inst.pulse(3, 3, 4);
        repeat (6) @(posedge ref_clk_i);
        rd(`OFS_EVT_COUNT, 32'h5);
        rd(`OFS_STATUS, 32'h2);
        sensor_model_inst.pulse(1, 1, 2);
        repeat (6) @(posedge ref_clk_i);
        rd(`OFS_EVT_COUNT, 32'h0);
        rd(`OFS_STATUS, 32'h12);
        apb(1'b1, `OFS_STATUS, 32'h12);
        rd(`OFS_STATUS, 32'h0);
        apb(1'b1, `OFS_CTRL, 32'h1);
        apb(1'b0, `OFS_FREE_TIME, 32'h0);
        t0 = q[15:0];
        sensor_model_inst.pulse(3, 4, 2);
        sensor_model_inst.pulse(0, 2, 2);
        repeat (6) @(posedge ref_clk_i);
        rd(`OFS_EVT_COUNT, 32'h4);
        rd(`OFS_CAP1_TIME, {16'h0, t0 + 16'h0014});
        apb(1'b1, `OFS_STATUS, 32'h2);
        apb(1'b1, `OFS_CTRL, 32'h3);
        apb(1'b1, `OFS_MASK, 32'h1);
        apb(1'b0, `OFS_FREE_TIME, 32'h0);
        t0 = q[15:0];
        sensor_model_inst.pulse(2, 1, 3);
        repeat (6) @(posedge ref_clk_i);
        chk({31'h0, cap0_irq_o}, 32'h1);
        rd(`OFS_EVT_COUNT, 32'h0);
        rd(`OFS_STATUS, 32'h11);
        rd(`OFS_CAP0_TIME, {16'h0, t0 + 16'h0005});
        apb(1'b1, `OFS_MASK, 32'h10);
        repeat (2) @(posedge ref_clk_i);
        chk({30'h0, irq_o, cap0_irq_o}, 32'h2);
        apb(1'b1, `OFS_STATUS, 32'h11);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h0);
        apb(1'b1, `OFS_CTRL, 32'h5);
        apb(1'b1, `OFS_CMD, 32'h0003_0003);
        rd(`OFS_STORE, 32'h1);
        sensor_model_inst.pulse(3, 3, 2);
        repeat (6) @(posedge ref_clk_i);
        rd(`OFS_EVT_COUNT, 32'h0);
        rd(`OFS_STORE, 32'h0);
        apb(1'b0, `OFS_FREE_TIME, 32'h0);
        apb(1'b1, `OFS_CMD, {11'h0, 2'd1, 2'd2, 1'b0, q[15:0] + 16'h003c});
        repeat (80) @(posedge ref_clk_i);
        chk({28'h0, compare_line_o}, 32'h2);
        rd(`OFS_STORE, 32'h200);
        apb(1'b1, `OFS_CMD, 32'h000f_0000);
        apb(1'b1, `OFS_CMD, 32'h0001_0000);
        repeat (2) @(posedge ref_clk_i);
        rd(`OFS_STORE, 32'h0);
        rd(`OFS_STATUS, 32'h16);
        repeat (9) apb(1'b1, `OFS_CMD, 32'h0001_ffff);
        rd(`OFS_STORE, 32'h8);
        apb(1'b1, `OFS_MASK, 32'h8);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h1);
        apb(1'b1, `OFS_STATUS, 32'h8);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h0);
        end_sim;
    end
endmodule
